/* rtl/pms_map.svh */
`ifndef PMS_MAP_SVH
`define PMS_MAP_SVH
// ==========================================
// Register byte offsets on the AXI4-Lite bus
`define PMS_OFS_CTRL      8'h00
`define PMS_OFS_START     8'h04
`define PMS_OFS_END       8'h08
`define PMS_OFS_CUR       8'h0C
`define PMS_OFS_STATUS    8'h10
`define PMS_OFS_TRIG      8'h14
// ==========================================
// Control register fields
`define PMS_CTRL_EN       0
`define PMS_CTRL_RUN      1
`define PMS_CTRL_MODE_LO  2
`define PMS_CTRL_MODE_HI  3
`define PMS_CTRL_IRQ_PRIORITY_SELECT     4
`define PMS_CTRL_IRQEN    5
// Status register field (write one to clear)
`define PMS_STAT_DONE     0
// ==========================================
// Widths and reset values
`define PMS_AW            16
`define PMS_TRIG_N        4
`define PMS_ADDR_RST      16'h0000
// ==========================================
// AXI responses
`define PMS_RESP_OKAY     2'h0
`define PMS_RESP_SLVERR   2'h2
`endif

/* rtl/pms_pkg.sv */
package pms_pkg;
   // ==========================================
   // Scan modes as coded in the mode field
   typedef enum logic [1:0]
   {
      pms_concurrent = 2'h0,
      pms_burst      = 2'h1,
      pms_peek       = 2'h2,
      pms_triggered  = 2'h3
   } pms_mode_type;
   // ==========================================
   // Sequencer states
   typedef enum logic [1:0] {st_idle, st_arm, st_read, st_load} pms_state_type;
   // ==========================================
   // Entire module state
   typedef struct packed
   {
      pms_state_type st;         // Sequencer state
      logic          en;         // Module enable
      logic          run;        // Scan running
      pms_mode_type  mode;       // Access mode
      logic          irq_priority_select;       // Interrupt priority select
      logic          irq_en;     // Done interrupt enable
      logic [1:0]    trig_sel;   // Trigger source
      logic          done;       // Sticky completion flag
      logic [15:0]   start;      // Scan start address
      logic [15:0]   endad;      // Scan end address
      logic [15:0]   cur;        // Current scan address
      logic [15:0]   data;       // Word handed to the checksum engine
      logic [3:0]    trig_s1;    // Trigger synchroniser stage 1
      logic [3:0]    trig_s2;    // Stage 2
      logic [3:0]    trig_s3;    // Stage 3
      logic [3:0]    trig_f;     // Filtered trigger levels
      logic          trig_seen;  // Trigger-seen flag; only ever cleared, never set
      logic          aw_got;     // Write address held
      logic [7:0]    awaddr;     // Held write address
      logic          w_got;      // Write data held
      logic [31:0]   wdata;      // Held write data
      logic [3:0]    wstrb;      // Held byte strobes
      logic          bvalid;     // Write response pending
      logic [1:0]    bresp;      // Write response code
      logic          rvalid;     // Read data pending
      logic [31:0]   rdata;      // Read data
      logic [1:0]    rresp;      // Read response code
   } pms_state_regs_type;
endpackage

/* rtl/pms_scanner.sv */
// Contract
// - Disable resets scanner state, keeps registers
// - First fetch waits for checksum running, ready
// - Stop at end or unimplemented, flag done
// - Software clearing run aborts, except burst
// - Done flag set after last word loaded
// - Only software clears done; enable gates irq
// - Burst mode stalls core until scan stops
// - Burst scan cannot be aborted by clearing run; only clearing enable stops it
// - Concurrent mode stalls core per access only
// - Triggered mode waits selected trigger rising edge
// - Peek mode uses only core idle flash cycles
// - Burst, priority one: interrupt pauses the burst
// - Non-burst, priority one: suspend during interrupt
// - Burst, priority zero: interrupt held until done
// - Non-burst, priority zero: keep scanning in interrupts
// - Scanner never touches the watchdog
// - Feed words while running and engine wants data
// - Engine ready means input word was consumed
`include "pms_map.svh"
`timescale 1ns/1ns
`default_nettype none
module pms_scanner
   import pms_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   // AXI4-Lite slave
   input  wire logic [7:0]              s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [7:0]              s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   // Flash read port shared with the core
   output logic                         flash_req,
   output logic [`PMS_AW-1:0]           flash_addr,
   input  wire logic [15:0]             flash_rdata,
   input  wire logic                    flash_unimpl,
   input  wire logic                    core_needs_flash,
   input  wire logic                    core_irq_active,
   output logic                         core_stall,
   output logic                         irq_hold,
   // Checksum engine input
   input  wire logic                    checksum_run,
   input  wire logic                    checksum_ready,
   output logic                         checksum_load,
   output logic [15:0]                  checksum_data,
   // Trigger sources from pins
   input  wire logic [`PMS_TRIG_N-1:0]  trig_in,
   // Completion interrupt request
   output logic                         scan_irq
);
   // ==========================================
   // State
   pms_state_regs_type q;        // Registered state
   pms_state_regs_type d;        // Next state
   logic               pause;    // Interrupt has priority over the scan
   logic               grant;    // Flash port may go to the scanner
   logic               fire;     // Flash read taken this cycle
   logic               trig_edge;// Rising edge on the selected trigger
   logic               wr_do;    // Held write is performed now
   logic               clr_done; // Software clears the done flag
   logic               burst_on; // Burst scan in progress

   // ==========================================
   // Byte-lane merge of a write into a register
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Register read mux; flag bit 32 marks an unmapped offset
   function automatic logic [32:0] rd_mux(input pms_state_regs_type s, input logic [7:0] a);
      logic [32:0] r;
      r = 33'h0;
      unique case (a)
         `PMS_OFS_CTRL:   r[5:0] = {s.irq_en, s.irq_priority_select, s.mode, s.run, s.en};
         `PMS_OFS_START:  r[15:0] = s.start;
         `PMS_OFS_END:    r[15:0] = s.endad;
         `PMS_OFS_CUR:    r[15:0] = s.cur;
         `PMS_OFS_STATUS: r[`PMS_STAT_DONE] = s.done;
         `PMS_OFS_TRIG:   r[1:0] = s.trig_sel;
         default:         r[32] = 1'b1;
      endcase
      return r;
   endfunction

   // ==========================================
   // Bus handshakes come straight from the state
   assign s_axi_awready = !q.aw_got && !q.bvalid;
   assign s_axi_wready  = !q.w_got && !q.bvalid;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;

   // ==========================================
   // Flash arbitration and core stall
   assign burst_on   = q.en && q.run && q.st != st_idle && q.mode == pms_burst;
   assign pause      = q.irq_priority_select && core_irq_active;
   // Peek only steals cycles the core leaves free, so its timing is unchanged
   assign grant      = !pause && !(q.mode == pms_peek && core_needs_flash);
   assign fire       = q.en && q.run && q.st == st_read && grant
                       && checksum_run && checksum_ready;
   assign flash_req  = fire;
   assign flash_addr = q.cur;
   // Burst holds the core the whole scan unless an interrupt with priority one pauses it; concurrent and triggered only while accessing, peek never
   assign core_stall = (burst_on && !pause)
                       || (fire && q.mode != pms_peek);
   // With priority zero a burst defers interrupt response to its end
   assign irq_hold   = burst_on && !q.irq_priority_select;
   assign checksum_load = q.st == st_load;
   assign checksum_data = q.data;
   assign scan_irq   = q.done && q.irq_en;
   // No watchdog connection: scan length cannot hide a hung core

   // ==========================================
   // Next-state logic
   always_comb
   begin
      logic [32:0] rd;
      logic [31:0] v;
      rd = 33'h0;
      v  = 32'h00000000;
      d  = q;
      wr_do    = q.aw_got && q.w_got && !q.bvalid;
      clr_done = 1'b0;
      // Trigger filter: level follows once stages two and three agree
      d.trig_s1 = trig_in;
      d.trig_s2 = q.trig_s1;
      d.trig_s3 = q.trig_s2;
      for (int i = 0; i < `PMS_TRIG_N; i++)
      begin
         if (q.trig_s2[i] == q.trig_s3[i])
         begin
            d.trig_f[i] = q.trig_s3[i];
         end
      end
      trig_edge = d.trig_f[q.trig_sel] && !q.trig_f[q.trig_sel];
      // Write address and data may arrive in either order
      if (s_axi_awvalid && s_axi_awready)
      begin
         d.aw_got = 1'b1;
         d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         d.w_got = 1'b1;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready)
      begin
         d.bvalid = 1'b0;
      end
      // Perform a held write
      if (wr_do)
      begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = `PMS_RESP_OKAY;
         unique case (q.awaddr)
            `PMS_OFS_CTRL:
            begin
               v = merge({26'h0, q.irq_en, q.irq_priority_select, q.mode, q.run, q.en}, q.wdata, q.wstrb);
               d.en     = v[`PMS_CTRL_EN];
               d.mode   = pms_mode_type'(v[`PMS_CTRL_MODE_HI:`PMS_CTRL_MODE_LO]);
               d.irq_priority_select   = v[`PMS_CTRL_IRQ_PRIORITY_SELECT];
               d.irq_en = v[`PMS_CTRL_IRQEN];
               // The core is frozen in a burst, so run cannot drop from software
               if (!burst_on)
               begin
                  d.run = v[`PMS_CTRL_RUN];
               end
               else
               begin
                  d.mode = q.mode;
               end
            end
            `PMS_OFS_START:  d.start = 16'(merge({16'h0000, q.start}, q.wdata, q.wstrb));
            `PMS_OFS_END:    d.endad = 16'(merge({16'h0000, q.endad}, q.wdata, q.wstrb));
            `PMS_OFS_STATUS: clr_done = q.wdata[`PMS_STAT_DONE] && q.wstrb[0];
            `PMS_OFS_TRIG:   d.trig_sel = 2'(merge({30'h0, q.trig_sel}, q.wdata, q.wstrb));
            `PMS_OFS_CUR:    d.bresp = `PMS_RESP_OKAY;
            default:         d.bresp = `PMS_RESP_SLVERR;
         endcase
      end
      // Reads answer one cycle after the address is taken
      if (s_axi_arvalid && s_axi_arready)
      begin
         rd      = rd_mux(q, s_axi_araddr);
         d.rvalid = 1'b1;
         d.rdata  = rd[31:0];
         d.rresp  = rd[32] ? `PMS_RESP_SLVERR : `PMS_RESP_OKAY;
      end
      else if (q.rvalid && s_axi_rready)
      begin
         d.rvalid = 1'b0;
      end
      if (clr_done)
      begin
         d.done = 1'b0;
      end
      // Scan sequencer
      unique case (q.st)
         st_idle:
         begin
            if (q.en && q.run)
            begin
               d.cur       = q.start;
               d.trig_seen = 1'b0;
               d.st        = st_arm;
            end
         end
         st_arm:
         begin
            if (q.mode != pms_triggered || q.trig_seen || trig_edge)
            begin
               d.st = st_read;
            end
            else
            begin
               d.trig_seen = 1'b0;
            end
         end
         st_read:
         begin
            if (fire && flash_unimpl)
            begin
               d.run  = 1'b0;
               d.done = 1'b1;
               d.st   = st_idle;
            end
            else if (fire)
            begin
               d.data = flash_rdata;
               d.st   = st_load;
            end
         end
         st_load:
         begin
            d.cur = q.cur + 16'h0001;
            if (q.cur == q.endad)
            begin
               // Hardware end wins over a same-cycle software write
               d.run  = 1'b0;
               d.done = 1'b1;
               d.st   = st_idle;
            end
            else
            begin
               d.st = st_read;
            end
         end
      endcase
      // Abort or disable returns to idle, registers kept; a word already fetched is still handed over
      if (!q.en || (!d.run && d.st != st_load))
      begin
         d.st        = st_idle;
         d.trig_seen = 1'b0;
      end
   end

   // ==========================================
   // State register
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   // ==========================================
   // Checks
   property p_crc_gate;
      @(posedge clk) disable iff (!rst_n) flash_req |-> checksum_run && checksum_ready;
   endproperty
   a_crc_gate: assert property (p_crc_gate) else $error("fetch without checksum ready");

   property p_end_stop;
      @(posedge clk) disable iff (!rst_n)
         checksum_load && q.cur == q.endad |=> !q.run && q.done && q.st == st_idle;
   endproperty
   a_end_stop: assert property (p_end_stop) else $error("scan did not stop at end");

   property p_unimpl_stop;
      @(posedge clk) disable iff (!rst_n) flash_req && flash_unimpl |=> !q.run && !checksum_load;
   endproperty
   a_unimpl_stop: assert property (p_unimpl_stop) else $error("unimplemented address loaded");

   property p_load_follows;
      @(posedge clk) disable iff (!rst_n)
         flash_req && !flash_unimpl |=> checksum_load && checksum_data == $past(flash_rdata);
   endproperty
   a_load_follows: assert property (p_load_follows) else $error("word not handed over");

   property p_advance;
      @(posedge clk) disable iff (!rst_n)
         checksum_load && q.run |=> q.cur == $past(q.cur) + 16'h0001;
   endproperty
   a_advance: assert property (p_advance) else $error("address did not advance");

   property p_done_sticky;
      @(posedge clk) disable iff (!rst_n) q.done && !clr_done |=> q.done;
   endproperty
   a_done_sticky: assert property (p_done_sticky) else $error("done flag lost");

   property p_peek_free;
      @(posedge clk) disable iff (!rst_n)
         flash_req && q.mode == pms_peek |-> !core_needs_flash && !core_stall;
   endproperty
   a_peek_free: assert property (p_peek_free) else $error("peek disturbed core");

   property p_suspend;
      @(posedge clk) disable iff (!rst_n) q.irq_priority_select && core_irq_active |-> !flash_req && !core_stall;
   endproperty
   a_suspend: assert property (p_suspend) else $error("scan ran during interrupt");

   property p_burst_hold;
      @(posedge clk) disable iff (!rst_n)
         burst_on && !q.irq_priority_select |-> core_stall && irq_hold;
   endproperty
   a_burst_hold: assert property (p_burst_hold) else $error("burst released core");

   property p_burst_run;
      @(posedge clk) disable iff (!rst_n) burst_on && q.st != st_load && !flash_req |=> q.run;
   endproperty
   a_burst_run: assert property (p_burst_run) else $error("burst aborted");

   property p_disable;
      @(posedge clk) disable iff (!rst_n) !q.en |=> q.st == st_idle;
   endproperty
   a_disable: assert property (p_disable) else $error("disabled scanner active");
endmodule
`default_nettype wire

/* sim/pms_partner.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Flash array and checksum engine input side
module pms_partner
#(
   parameter logic [15:0] UNIMPL_BASE = 16'h0100  // First unimplemented word
)
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        engine_on,
   input  wire logic        slow,
   input  wire logic        flash_req,
   input  wire logic [15:0] flash_addr,
   output logic [15:0]      flash_rdata,
   output logic             flash_unimpl,
   output logic             checksum_run,
   output logic             checksum_ready,
   input  wire logic        checksum_load,
   input  wire logic [15:0] checksum_data,
   output logic [15:0]      loads,
   output logic [15:0]      last_word
);
   logic [15:0] idle_q;  // Last word read; inverted while the port is released
   logic [2:0]  busy_q;  // Shift cycles left for the word held
   assign checksum_run   = engine_on;
   assign checksum_ready = engine_on && busy_q == 3'h0;
   assign flash_unimpl   = flash_req && flash_addr >= UNIMPL_BASE;
   // Released port shows no stale data, so a late sample cannot pass
   assign flash_rdata    = flash_req ? (flash_addr ^ 16'hA5A5) : ~idle_q;
   // Engine drops ready the cycle after a load, longer when slow
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         busy_q <= 3'h0;
         loads  <= 16'h0;
      end
      else if (checksum_load)
      begin
         busy_q    <= slow ? 3'h5 : 3'h1;
         loads     <= loads + 16'h1;
         last_word <= checksum_data;
      end
      else if (busy_q != 3'h0)
         busy_q <= busy_q - 3'h1;
      if (flash_req)
         idle_q <= flash_rdata;
   end
endmodule
`default_nettype wire

/* sim/testbench.sv */
`include "pms_map.svh"
`timescale 1ns/1ns
`default_nettype none
module testbench
   import pms_pkg::*;
;
   // ==========================================
   // Signals
   logic         clk = 0;
   logic         rst_n = 0;
   logic [7:0]   s_axi_awaddr, s_axi_araddr;
   logic         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0]  s_axi_wdata, s_axi_rdata, rv;
   logic [3:0]   s_axi_wstrb, trig_in;
   logic [1:0]   s_axi_bresp, s_axi_rresp, rr;
   logic         flash_req, flash_unimpl, core_needs_flash, core_irq_active, core_stall, irq_hold;
   logic         checksum_run, checksum_ready, checksum_load, scan_irq, engine_on, slow;
   logic [15:0]  flash_addr, flash_rdata, checksum_data, loads, last_word;
   int           miscompares = 0, num_checks = 0, cycles = 0, bad = 0, holds = 0;
   pms_mode_type tb_mode = pms_concurrent;
   logic         tb_irq_priority_select = 0;
   pms_scanner pms_scanner_inst
   (
      .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .flash_req, .flash_addr, .flash_rdata, .flash_unimpl, .core_needs_flash, .core_irq_active,
      .core_stall, .irq_hold, .checksum_run, .checksum_ready, .checksum_load, .checksum_data,
      .trig_in, .scan_irq
   );
   pms_partner #(.UNIMPL_BASE(16'h0100)) pms_partner_inst
   (
      .clk, .rst_n, .engine_on, .slow, .flash_req, .flash_addr, .flash_rdata, .flash_unimpl,
      .checksum_run, .checksum_ready, .checksum_load, .checksum_data, .loads, .last_word
   );
   always #50 clk = ~clk;
   // ==========================================
   // Core fetch pattern and timeout
   always @(posedge clk)
   begin
      cycles           <= cycles + 1;
      core_needs_flash <= cycles[1:0] != 2'h0;
   end
   // Port watch at mid-cycle, where combinational outputs have settled
   always @(negedge clk)
   begin
      if (irq_hold)
         holds <= holds + 1;
      if (tb_mode == pms_peek && ((flash_req && core_needs_flash) || core_stall))
         bad <= bad + 1;
      if (tb_mode != pms_peek && flash_req && !core_stall)
         bad <= bad + 1;
      if (tb_mode != pms_burst && tb_irq_priority_select && core_irq_active && flash_req)
         bad <= bad + 1;
      if (tb_mode == pms_burst && tb_irq_priority_select && core_irq_active && core_stall)
         bad <= bad + 1;
      if (irq_hold && (tb_mode != pms_burst || tb_irq_priority_select))
         bad <= bad + 1;
      // A burst without priority keeps the core stalled between fetches too
      if (tb_mode == pms_burst && irq_hold && !core_stall)
         bad <= bad + 1;
   end
   // ==========================================
   // Shared tasks
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Write: address and data offered together, each dropped once taken
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, hit;
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(negedge clk);
         ta  = s_axi_awvalid & s_axi_awready;
         tw  = s_axi_wvalid & s_axi_wready;
         hit = s_axi_bvalid;
         rr  = s_axi_bresp;
         @(posedge clk);
         if (ta)
            s_axi_awvalid <= 1'b0;
         if (tw)
            s_axi_wvalid <= 1'b0;
      end while (!hit);
      s_axi_bready <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      logic ta, hit;
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(negedge clk);
         ta  = s_axi_arvalid & s_axi_arready;
         hit = s_axi_rvalid;
         rv  = s_axi_rdata;
         rr  = s_axi_rresp;
         @(posedge clk);
         if (ta)
            s_axi_arvalid <= 1'b0;
      end while (!hit);
      s_axi_rready <= 1'b0;
   endtask
   // Control word: irq enable, priority, mode, run, enable
   function automatic logic [31:0] ctl(input logic run, input pms_mode_type m, input logic irq_priority_select);
      return {26'h0, 1'b1, irq_priority_select, m, run, 1'b1};
   endfunction
   task wait_done;
      for (int i = 0; i < 2000 && !scan_irq; i++)
         @(negedge clk);
   endtask
   // ==========================================
   // Scenarios
   task t_regs;
      rd(`PMS_OFS_START);
      check("start reset", rv, 32'h0);
      rd(8'h18);
      check("unmapped read resp", rr, `PMS_RESP_SLVERR);
      check("unmapped read data", rv, 32'h0);
      wr(`PMS_OFS_CUR, 32'h1234);
      check("cur write resp", rr, `PMS_RESP_OKAY);
      rd(`PMS_OFS_CUR);
      check("cur read only", rv, 32'h0);
      wr(8'h20, 32'h1);
      check("unmapped write resp", rr, `PMS_RESP_SLVERR);
      $display("test regs done");
   endtask
   task t_scan(input pms_mode_type m, input logic irq_priority_select, input logic [15:0] s, input logic [15:0] e,
               input logic [15:0] n, input logic irq);
      logic [15:0] n0;
      int          h0;
      tb_mode    = m;
      tb_irq_priority_select    = irq_priority_select;
      h0         = holds;
      engine_on <= 1'b0;
      n0         = loads;
      wr(`PMS_OFS_START, {16'h0, s});
      wr(`PMS_OFS_END, {16'h0, e});
      wr(`PMS_OFS_TRIG, 32'h2);
      wr(`PMS_OFS_CTRL, ctl(1'b1, m, irq_priority_select));
      repeat (8) @(posedge clk);
      check("fetch before engine ready", loads - n0, 16'h0);
      engine_on <= 1'b1;
      if (m == pms_triggered)
      begin
         // Edge on an unselected source must not start the scan
         trig_in <= 4'h2;
         repeat (8) @(posedge clk);
         check("start before trigger", loads - n0, 16'h0);
         trig_in <= 4'h4;
      end
      core_irq_active <= irq;
      repeat (30) @(posedge clk);
      core_irq_active <= 1'b0;
      trig_in         <= 4'h0;
      wait_done;
      check("word count", loads - n0, n);
      check("last word", last_word, (s + n - 16'h1) ^ 16'hA5A5);
      check("port rules", bad, 0);
      if (m == pms_burst && !irq_priority_select)
         check("irq held off", holds > h0, 1'b1);
      rd(`PMS_OFS_CTRL);
      check("run cleared", rv[1], 1'b0);
      rd(`PMS_OFS_STATUS);
      check("done flag", rv[0], 1'b1);
      check("irq line", scan_irq, 1'b1);
      // Enable off hides the request but the flag must survive
      wr(`PMS_OFS_CTRL, 32'h1);
      check("irq gated", scan_irq, 1'b0);
      wr(`PMS_OFS_CTRL, 32'h21);
      check("irq restored", scan_irq, 1'b1);
      wr(`PMS_OFS_STATUS, 32'h1);
      check("irq cleared", scan_irq, 1'b0);
      rd(`PMS_OFS_STATUS);
      check("done cleared", rv[0], 1'b0);
      $display("test scan mode %0d done", m);
   endtask
   // Stop word either clears run (abort) or clears enable mid-scan
   task t_stop(input pms_mode_type m, input logic [31:0] stopw);
      logic [15:0] n0;
      tb_mode  = m;
      tb_irq_priority_select  = 1'b0;
      slow    <= 1'b1;
      n0       = loads;
      wr(`PMS_OFS_START, 32'h5);
      wr(`PMS_OFS_END, 32'h44);
      wr(`PMS_OFS_CTRL, ctl(1'b1, m, 1'b0));
      repeat (20) @(posedge clk);
      wr(`PMS_OFS_CTRL, stopw);
      if (m == pms_burst)
      begin
         wait_done;
         check("burst runs to end", loads - n0, 16'h40);
         wr(`PMS_OFS_STATUS, 32'h1);
      end
      else
      begin
         repeat (4) @(posedge clk);
         n0 = loads;
         repeat (20) @(posedge clk);
         check("scan halted", loads - n0, 16'h0);
         rd(`PMS_OFS_START);
         check("start kept", rv, 32'h5);
         rd(`PMS_OFS_STATUS);
         check("no done on stop", rv[0], 1'b0);
         wr(`PMS_OFS_CTRL, 32'h0);
      end
      slow <= 1'b0;
      $display("test stop mode %0d done", m);
   endtask
   // ==========================================
   // Main sequence
   initial
   begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {trig_in, core_irq_active, engine_on, slow} = '0;
      s_axi_wstrb = 4'hF;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      fork
         begin
            t_regs;
            t_scan(pms_concurrent, 1'b0, 16'h0010, 16'h0013, 16'h4, 1'b0);
            t_scan(pms_burst, 1'b0, 16'h0020, 16'h0027, 16'h8, 1'b1);
            t_scan(pms_burst, 1'b1, 16'h0020, 16'h0027, 16'h8, 1'b1);
            t_scan(pms_peek, 1'b0, 16'h0030, 16'h0033, 16'h4, 1'b1);
            t_scan(pms_triggered, 1'b1, 16'h0040, 16'h0043, 16'h4, 1'b1);
            t_scan(pms_concurrent, 1'b1, 16'h00FD, 16'h0110, 16'h3, 1'b0);
            t_stop(pms_burst, ctl(1'b0, pms_burst, 1'b0));
            t_stop(pms_concurrent, ctl(1'b0, pms_concurrent, 1'b0));
            t_stop(pms_concurrent, 32'h2);
         end
         begin
            // Ceiling well above the some 1200 cycles the scenarios need
            wait (cycles >= 30000);
            miscompares++;
         end
      join_any
      report_and_stop;
   end
endmodule
`default_nettype wire
